/* hcs_pkg.sv */
// Constants, types and field layout for the host control and error status bits
package hcs_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_NMASK = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_FMASK = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_CFG   = 4'hC;

    // Field positions
    localparam int BIT_CPU_PAR  = 4;
    localparam int BIT_PCI_PAR  = 5;
    localparam int BIT_DMA_PAR  = 6;
    localparam int BIT_DISCARD  = 8;
    localparam int BIT_PCI_NRST = 9;
    localparam int LSIZE_LO     = 10;
    localparam int LSIZE_HI     = 12;
    localparam int CFG_PAR_EN   = 0;

    localparam int NUM_FLAGS = 4;
    localparam int FLAG_POS [0:NUM_FLAGS-1] = '{4, 5, 6, 8};
    localparam logic [DATA_W-1:0] FLAG_MASK = 32'h0000_0170;

    // Reset values
    localparam logic [DATA_W-1:0] RST_MASK  = 32'h0000_0000;
    localparam logic              RST_NRST  = 1'h0;
    localparam logic [2:0]        RST_LSIZE = 3'h0;
    localparam logic              RST_PAREN = 1'h0;
    localparam logic [16:0]       RST_PTR_MASK = 17'h003FC;

    // Pointer counting span
    localparam int PTR_LO      = 2;
    localparam int PTR_BASE_HI = 9;
    localparam int PTR_W       = 17;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } hcs_bus_state_t;

    typedef struct packed {
        logic cpu_rd_parity;
        logic pci_rd_parity;
        logic dma_rd_parity;
        logic discard_timer_zero;
        logic read_data_discarded;
    } hcs_events_t;

endpackage

/* hcs_flag.sv */
// Sticky error flag with configurable clearing data value
`timescale 1ns/1ps
module hcs_flag #(
    parameter logic CLEAR_ON = 1'h1
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic wr_en,
    input  wire logic wr_bit,
    output logic      q
);

    logic next_q;

    // Set beats a clearing write
    always_comb begin
        next_q = q;
        if (set) begin
            next_q = 1'b1;
        end else if (wr_en && (wr_bit == CLEAR_ON)) begin
            next_q = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

endmodule // hcs_flag

/* hcs_ptr_mask.sv */
// Decode of list size code into counting pointer bits
`timescale 1ns/1ps
module hcs_ptr_mask (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [2:0]               list_size,
    output logic [hcs_pkg::PTR_W-1:0]     count_mask
);

    logic [hcs_pkg::PTR_W-1:0] next_mask;
    logic [4:0]                top_bit;

    always_comb begin
        top_bit   = 5'(hcs_pkg::PTR_BASE_HI) + {2'h0, list_size};
        next_mask = '0;
        for (int b = hcs_pkg::PTR_LO; b < hcs_pkg::PTR_W; b++) begin
            next_mask[b] = (5'(b) <= top_bit);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_mask <= hcs_pkg::RST_PTR_MASK;
        end else begin
            count_mask <= next_mask;
        end
    end

endmodule // hcs_ptr_mask

/* hcs_top.sv */
// Host control and error status bits with Avalon-MM register slave
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module hcs_top (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [hcs_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire hcs_pkg::hcs_events_t        err_events,
    input  wire logic                        central_fn,
    input  wire logic                        h2p_enq_req,
    output logic                             h2p_enq_accept,
    output logic                             pci_rst_n,
    output logic                             fifo_flush,
    output logic                             normal_irq,
    output logic                             fast_irq,
    output logic [hcs_pkg::PTR_W-1:0]        ptr_count_mask
);

    // Bus slave state
    hcs_pkg::hcs_bus_state_t state;
    hcs_pkg::hcs_bus_state_t next_state;
    logic                    next_wait;
    logic [31:0]             next_rdata;

    // Register state
    logic [31:0] nmask;
    logic [31:0] fmask;
    logic        pci_not_rst;
    logic [2:0]  list_size;
    logic        par_en;
    logic [31:0] next_nmask;
    logic [31:0] next_fmask;
    logic        next_pci_not_rst;
    logic [2:0]  next_list_size;
    logic        next_par_en;

    // Output state
    logic next_nirq;
    logic next_firq;
    logic next_pci_rst_n;
    logic next_flush;
    logic next_accept;

    // Flags and write decode
    logic [hcs_pkg::NUM_FLAGS-1:0] flag_set;
    logic [hcs_pkg::NUM_FLAGS-1:0] flag_q;
    logic [31:0]                   flags_vec;
    logic [31:0]                   wmask;
    logic [31:0]                   ctrl_rd;
    logic [31:0]                   rd_mux;
    logic                          wr_fire;
    logic                          ctrl_wr;
    logic                          nmask_wr;
    logic                          fmask_wr;
    logic                          cfg_wr;

    // Write strobes valid only on the accepting edge
    assign wr_fire  = (state == hcs_pkg::ST_ACK) && avs_write;
    assign ctrl_wr  = wr_fire && (avs_address == hcs_pkg::OFF_CTRL);
    assign nmask_wr = wr_fire && (avs_address == hcs_pkg::OFF_NMASK);
    assign fmask_wr = wr_fire && (avs_address == hcs_pkg::OFF_FMASK);
    assign cfg_wr   = wr_fire && (avs_address == hcs_pkg::OFF_CFG);
    assign wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Event sources
    assign flag_set[0] = err_events.cpu_rd_parity && par_en;
    assign flag_set[1] = err_events.pci_rd_parity && par_en;
    assign flag_set[2] = err_events.dma_rd_parity && par_en;
    assign flag_set[3] = err_events.discard_timer_zero
                         && err_events.read_data_discarded;

    // Sticky flags, parity W1C and discard W0C
    generate
        for (genvar i = 0; i < hcs_pkg::NUM_FLAGS; i++) begin : g_flag
            localparam int POS = hcs_pkg::FLAG_POS[i];
            hcs_flag #(
                .CLEAR_ON (POS == hcs_pkg::BIT_DISCARD ? 1'h0 : 1'h1)
            ) u_flag (
                .core_clk (core_clk),
                .rst      (rst),
                .set      (flag_set[i]),
                .wr_en    (ctrl_wr && wmask[POS]),
                .wr_bit   (avs_writedata[POS]),
                .q        (flag_q[i])
            );
            assign flags_vec[POS] = flag_q[i];
        end
    endgenerate

    assign flags_vec[3:0]   = 4'h0;
    assign flags_vec[7]     = 1'b0;
    assign flags_vec[31:9]  = 23'h0;

    // Control register readback
    always_comb begin
        ctrl_rd = flags_vec;
        ctrl_rd[hcs_pkg::BIT_PCI_NRST] = pci_not_rst;
        ctrl_rd[hcs_pkg::LSIZE_HI:hcs_pkg::LSIZE_LO] = list_size;
    end

    always_comb begin
        case (avs_address)
            hcs_pkg::OFF_CTRL:  rd_mux = ctrl_rd;
            hcs_pkg::OFF_NMASK: rd_mux = nmask;
            hcs_pkg::OFF_FMASK: rd_mux = fmask;
            hcs_pkg::OFF_CFG:   rd_mux = {31'h0, par_en};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus handshake: one wait cycle, then accept
    always_comb begin
        next_state = state;
        next_wait  = avs_waitrequest;
        next_rdata = avs_readdata;
        case (state)
            hcs_pkg::ST_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state = hcs_pkg::ST_ACK;
                    next_wait  = 1'b0;
                    next_rdata = avs_read ? rd_mux : 32'h0000_0000;
                end
            end
            hcs_pkg::ST_ACK: begin
                next_state = hcs_pkg::ST_IDLE;
                next_wait  = 1'b1;
            end
            default: begin
                next_state = hcs_pkg::ST_IDLE;
                next_wait  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state           <= hcs_pkg::ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            state           <= next_state;
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_rdata;
        end
    end

    // Software writable fields
    always_comb begin
        next_nmask       = nmask;
        next_fmask       = fmask;
        next_pci_not_rst = pci_not_rst;
        next_list_size   = list_size;
        next_par_en      = par_en;
        if (nmask_wr) begin
            next_nmask = ((nmask & ~wmask) | (avs_writedata & wmask)) & hcs_pkg::FLAG_MASK;
        end
        if (fmask_wr) begin
            next_fmask = ((fmask & ~wmask) | (avs_writedata & wmask)) & hcs_pkg::FLAG_MASK;
        end
        if (ctrl_wr && avs_byteenable[1]) begin
            next_pci_not_rst = avs_writedata[hcs_pkg::BIT_PCI_NRST];
            next_list_size   = avs_writedata[hcs_pkg::LSIZE_HI:hcs_pkg::LSIZE_LO];
        end
        if (cfg_wr && avs_byteenable[0]) begin
            next_par_en = avs_writedata[hcs_pkg::CFG_PAR_EN];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nmask       <= hcs_pkg::RST_MASK;
            fmask       <= hcs_pkg::RST_MASK;
            pci_not_rst <= hcs_pkg::RST_NRST;
            list_size   <= hcs_pkg::RST_LSIZE;
            par_en      <= hcs_pkg::RST_PAREN;
        end else begin
            nmask       <= next_nmask;
            fmask       <= next_fmask;
            pci_not_rst <= next_pci_not_rst;
            list_size   <= next_list_size;
            par_en      <= next_par_en;
        end
    end

    // Interrupts, PCI reset, flush and enqueue gate
    always_comb begin
        next_nirq      = |(flags_vec & nmask);
        next_firq      = |(flags_vec & fmask);
        next_pci_rst_n = pci_not_rst || !central_fn;
        next_flush     = !pci_not_rst;
        next_accept    = h2p_enq_req && pci_not_rst;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            normal_irq     <= 1'b0;
            fast_irq       <= 1'b0;
            pci_rst_n      <= 1'b1;
            fifo_flush     <= 1'b1;
            h2p_enq_accept <= 1'b0;
        end else begin
            normal_irq     <= next_nirq;
            fast_irq       <= next_firq;
            pci_rst_n      <= next_pci_rst_n;
            fifo_flush     <= next_flush;
            h2p_enq_accept <= next_accept;
        end
    end

    // Pointer counting span from list size
    hcs_ptr_mask u_ptr_mask (
        .core_clk   (core_clk),
        .rst        (rst),
        .list_size  (list_size),
        .count_mask (ptr_count_mask)
    );

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_req_idle;
        (avs_read || avs_write) && (state == hcs_pkg::ST_IDLE);
    endsequence

    sequence s_accept_then_wait;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    sequence s_w1c_clear(int p, int i);
        ctrl_wr && avs_byteenable[0] && avs_writedata[p] && !flag_set[i];
    endsequence

    a_bus_accept: assert property (s_req_idle |=> s_accept_then_wait)
        else $error("bus request not accepted after one wait cycle");

    a_cpu_par_set: assert property (flag_set[0] |=> flags_vec[4] [*1] ##0 ctrl_rd[4])
        else $error("cpu parity flag not set");

    a_pci_par_set: assert property (err_events.pci_rd_parity && par_en |=> flag_q[1])
        else $error("pci parity flag not set");

    a_dma_par_set: assert property (err_events.dma_rd_parity && par_en |=> flag_q[2])
        else $error("dma parity flag not set");

    a_par_gated_off: assert property (!par_en && !flag_q[0] && !ctrl_wr |=> !flag_q[0])
        else $error("cpu parity flag set while checking off");

    a_w1c_clears: assert property (s_w1c_clear(4, 0) |=> !flag_q[0])
        else $error("write one did not clear cpu parity flag");

    a_set_beats_clr: assert property (flag_set[1] && ctrl_wr |=> flag_q[1])
        else $error("new parity error lost under clear");

    a_w0_keeps_par: assert property (flag_q[2] && ctrl_wr && !avs_writedata[6] |=> flag_q[2])
        else $error("write zero cleared dma parity flag");

    a_discard_set: assert property (flag_set[3] |=> flag_q[3] ##0 ctrl_rd[8])
        else $error("discard flag not set");

    a_discard_w1_keep: assert property (flag_q[3] && ctrl_wr && avs_writedata[8]
        |=> flag_q[3])
        else $error("write one changed discard flag");

    a_discard_w0_clr: assert property (ctrl_wr && avs_byteenable[1] && !avs_writedata[8]
        && !flag_set[3] |=> !flag_q[3])
        else $error("write zero did not clear discard flag");

    a_irq_follow: assert property ((|(flags_vec & nmask)) |=> normal_irq)
        else $error("normal interrupt not raised");

    a_irq_drop: assert property (!(|(flags_vec & nmask)) |=> !normal_irq)
        else $error("normal interrupt without unmasked flag");

    a_fiq_quiet: assert property (fmask == 32'h0 |=> !fast_irq)
        else $error("fast interrupt with all masked");

    a_rst_held_off: assert property (pci_not_rst |=> pci_rst_n)
        else $error("pci reset asserted while suppressed");

    a_rst_driven: assert property (!pci_not_rst && central_fn |=> !pci_rst_n && fifo_flush)
        else $error("pci reset or flush missing");

    a_enq_refused: assert property (!pci_not_rst |=> !h2p_enq_accept)
        else $error("enqueue accepted during pci reset");

    a_ptr_span: assert property (list_size == 3'h7 && $stable(list_size)
        |=> ptr_count_mask == 17'h1FFFC)
        else $error("largest list span wrong");

    a_ptr_base: assert property (list_size == 3'h0 [*2] |=> ptr_count_mask == 17'h003FC)
        else $error("smallest list span wrong");

endmodule // hcs_top

/* hcs_host_model.sv */
// Host processor model issuing register reads and writes
`timescale 1ns/1ps
module hcs_host_model (
    input  wire logic                       core_clk,
    output logic      [hcs_pkg::ADDR_W-1:0] avs_address,
    output logic                            avs_read,
    output logic                            avs_write,
    output logic      [31:0]                avs_writedata,
    output logic      [3:0]                 avs_byteenable,
    input  wire logic [31:0]                avs_readdata,
    input  wire logic                       avs_waitrequest
);
    initial begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = '0;
    end

    // One access, held until waitrequest is seen low
    task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write      <= 1'b0;
        avs_read       <= 1'b0;
        avs_address    <= ~a;
        avs_writedata  <= ~d;
    endtask
endmodule // hcs_host_model

/* host_ctrl_error_status_bits_test.sv */
// Self-checking bench for the host control and error status bits
`timescale 1ns/1ps
module host_ctrl_error_status_bits_test;
    logic                      core_clk = 1'b0;
    logic                      rst;
    logic [3:0]                avs_address;
    logic                      avs_read;
    logic                      avs_write;
    logic [31:0]               avs_writedata;
    logic [3:0]                avs_byteenable;
    logic [31:0]               avs_readdata;
    logic                      avs_waitrequest;
    hcs_pkg::hcs_events_t      err_events;
    logic                      central_fn;
    logic                      h2p_enq_req;
    logic                      h2p_enq_accept;
    logic                      pci_rst_n;
    logic                      fifo_flush;
    logic                      normal_irq;
    logic                      fast_irq;
    logic [16:0]               ptr_count_mask;
    int                        fail_count = 0;
    int                        checked = 0;
    logic [31:0]               rd;
    logic [31:0]               b;

    always #10 core_clk = ~core_clk;

    hcs_top hcs_top_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .err_events(err_events),
        .central_fn(central_fn), .h2p_enq_req(h2p_enq_req),
        .h2p_enq_accept(h2p_enq_accept), .pci_rst_n(pci_rst_n), .fifo_flush(fifo_flush),
        .normal_irq(normal_irq), .fast_irq(fast_irq), .ptr_count_mask(ptr_count_mask));

    hcs_host_model hcs_host_model_i (.core_clk(core_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        hcs_host_model_i.access(1'b1, a, d, be, rd);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        hcs_host_model_i.access(1'b0, a, 32'h0, 4'hF, rd);
        chk(rd, exp, what);
    endtask

    task automatic pulse(input logic [4:0] ev);
        @(posedge core_clk);
        err_events <= hcs_pkg::hcs_events_t'(ev);
        @(posedge core_clk);
        err_events <= '0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        err_events = '0;
        central_fn = 1'b1;
        h2p_enq_req = 1'b1;
        rst = 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd_chk(hcs_pkg::OFF_CTRL, 32'h0, "ctrl reset");
        rd_chk(hcs_pkg::OFF_NMASK, 32'h0, "nmask reset");
        wr(4'h2, 32'hFFFF_FFFF, 4'hF);
        rd_chk(4'h2, 32'h0, "unmapped read");
        chk1(pci_rst_n, 1'b0, "pci reset after reset");
        chk1(fifo_flush, 1'b1, "flush after reset");
        chk1(h2p_enq_accept, 1'b0, "enqueue refused");
        chk({15'h0, ptr_count_mask}, 32'h0000_03FC, "mask code 0");
        $display("done: reset state");
        pulse(5'h1C);
        rd_chk(hcs_pkg::OFF_CTRL, 32'h0, "parity check off");
        wr(hcs_pkg::OFF_CFG, 32'h1, 4'hF);
        wr(hcs_pkg::OFF_NMASK, 32'hFFFF_FFFF, 4'hF);
        rd_chk(hcs_pkg::OFF_NMASK, 32'h0000_0170, "nmask writable bits");
        wr(hcs_pkg::OFF_FMASK, 32'h0000_0100, 4'hF);
        rd_chk(hcs_pkg::OFF_FMASK, 32'h0000_0100, "fmask readback");
        rd_chk(hcs_pkg::OFF_CFG, 32'h0000_0001, "parity enable readback");
        for (int i = 0; i < 3; i++) begin
            b = 32'h10 << i;
            pulse(5'h10 >> i);
            rd_chk(hcs_pkg::OFF_CTRL, b, "parity flag set");
            chk1(normal_irq, 1'b1, "normal irq raised");
            chk1(fast_irq, 1'b0, "fast irq masked");
            wr(hcs_pkg::OFF_CTRL, 32'h0, 4'h1);
            rd_chk(hcs_pkg::OFF_CTRL, b, "zero write keeps");
            wr(hcs_pkg::OFF_CTRL, b, 4'h1);
            rd_chk(hcs_pkg::OFF_CTRL, 32'h0, "one write clears");
            chk1(normal_irq, 1'b0, "normal irq dropped");
        end
        fork
            wr(hcs_pkg::OFF_CTRL, 32'h10, 4'h1);
            begin
                @(negedge avs_waitrequest);
                err_events <= hcs_pkg::hcs_events_t'(5'h10);
                @(posedge core_clk);
                err_events <= '0;
            end
        join
        rd_chk(hcs_pkg::OFF_CTRL, 32'h10, "set beats clear");
        wr(hcs_pkg::OFF_CTRL, 32'h10, 4'h1);
        $display("done: parity flags");
        pulse(5'h02);
        rd_chk(hcs_pkg::OFF_CTRL, 32'h0, "timer zero alone");
        pulse(5'h03);
        rd_chk(hcs_pkg::OFF_CTRL, 32'h100, "discard flag set");
        chk1(fast_irq, 1'b1, "fast irq raised");
        wr(hcs_pkg::OFF_CTRL, 32'h100, 4'h2);
        rd_chk(hcs_pkg::OFF_CTRL, 32'h100, "one write keeps");
        wr(hcs_pkg::OFF_CTRL, 32'h0, 4'h2);
        rd_chk(hcs_pkg::OFF_CTRL, 32'h0, "zero write clears");
        chk1(fast_irq, 1'b0, "fast irq dropped");
        $display("done: discard flag");
        @(posedge core_clk);
        central_fn <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk1(pci_rst_n, 1'b1, "no strap no reset");
        chk1(fifo_flush, 1'b1, "flush while bit low");
        central_fn <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk1(pci_rst_n, 1'b0, "strap gives reset");
        wr(hcs_pkg::OFF_CTRL, 32'h200, 4'h2);
        repeat (3) @(posedge core_clk);
        chk1(pci_rst_n, 1'b1, "suppress holds off");
        chk1(fifo_flush, 1'b0, "flush released");
        chk1(h2p_enq_accept, 1'b1, "enqueue taken");
        h2p_enq_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk1(h2p_enq_accept, 1'b0, "no request no accept");
        h2p_enq_req <= 1'b1;
        $display("done: pci reset");
        for (int k = 0; k < 8; k++) begin
            b = 32'h200 | (k << 10);
            wr(hcs_pkg::OFF_CTRL, b, 4'h2);
            rd_chk(hcs_pkg::OFF_CTRL, b, "list size readback");
            chk({15'h0, ptr_count_mask}, ((32'h1 << (k + 8)) - 1) << 2, "count mask");
        end
        wr(hcs_pkg::OFF_CTRL, 32'h0, 4'h2);
        repeat (3) @(posedge core_clk);
        chk1(h2p_enq_accept, 1'b0, "enqueue refused again");
        chk1(pci_rst_n, 1'b0, "software reset again");
        $display("done: list size");
        tally_and_finish();
    end
endmodule // host_ctrl_error_status_bits_test
